// >>> core/ffp_pkg.sv
package ffp_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses, one word each)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_COUNT = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_MASK = 8'h0c;
  localparam logic [7:0] OFS_STATE = 8'h10;
  localparam logic [7:0] OFS_ONCAP = 8'h14;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_OVLATCH_BIT = 1;
  localparam int CTRL_UVLONG_BIT = 2;
  localparam int CNT_OV_LSB = 0;
  localparam int CNT_UV_LSB = 8;
  localparam int CNT_CSSP_LSB = 16;
  localparam int CNT_SECONDARY_SHORT_FAULT_LSB = 24;
  localparam int EVT_OV = 0;
  localparam int EVT_UV = 1;
  localparam int EVT_CSSP = 2;
  localparam int EVT_SECONDARY_SHORT_FAULT = 3;
  localparam int EVT_OLP = 4;
  localparam int NUM_EVT = 5;
  localparam int NUM_CNT = 4;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [2:0] RST_CTRL = 3'h1;
  localparam logic [31:0] RST_COUNT = 32'h0404_0404;
  localparam logic [15:0] RST_ONCAP = 16'h0064;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int CS_DEBOUNCE_NS = 300;
  localparam int CS_DEBOUNCE_CYC = (CS_DEBOUNCE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SECONDARY_SHORT_FAULT_BLANK_NS = 200;
  localparam int SECONDARY_SHORT_FAULT_BLANK_CYC = (SECONDARY_SHORT_FAULT_BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OLP_DEBOUNCE_NS = 50000000;
  localparam int AR_PERIOD_NS = 1000000;
  localparam int LAR_PERIOD_NS = 10000000;
  localparam int UV_BLANK_NS = 20000000;

  // ----------------------------------------------------------------
  // Protection states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_AR = 2'b01,
    ST_LAR = 2'b10,
    ST_LATCH = 2'b11
  } ffp_state_t;

endpackage : ffp_pkg

// >>> core/ffp_cycle_counter.sv
`timescale 1ns/1ns
module ffp_cycle_counter #(
  parameter int W = 9
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // Counting control
  input wire logic clear,
  input wire logic step,
  input wire logic cond,
  input wire logic [W-1:0] limit,
  // Result
  output logic trip
);

  typedef struct packed {
    logic [W-1:0] count;
    logic trip;
  } ffp_cnt_s_t;

  ffp_cnt_s_t s;
  ffp_cnt_s_t next_s;

  // Consecutive-cycle count; a clean cycle starts over
  always_comb begin
    next_s = s;
    next_s.trip = 1'b0;
    if (clear) begin
      next_s.count = '0;
    end else if (step) begin
      if (cond) begin
        if (s.count + 1'b1 >= limit) begin
          next_s.trip = 1'b1;
          next_s.count = '0;
        end else begin
          next_s.count = s.count + 1'b1;
        end
      end else begin
        next_s.count = '0;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign trip = s.trip;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  a_clean_cycle_restart: assert property (step && !cond && !clear |=> s.count == '0)
    else $error("counter kept counting after a clean cycle");

endmodule : ffp_cycle_counter

// >>> core/ffp_fault_protect.sv
`timescale 1ns/1ns
// Contract
// - Aux over-voltage run stops switching, restart or latch
// - Aux under-voltage run flags fault, restart or long
// - Under-voltage ignored during startup blanking
// - Sense short after debounce caps on-time
// - Repeated sense short cycles stop, auto-restart
// - Secondary short after blanking turns switch off
// - Repeated secondary short cycles stop, auto-restart
// - Overload threshold starts overload timer
// - Overload timer past debounce: fault, auto-restart
// - Feedback drop before debounce clears timer
// - Long restart holds switch off, resumes on supply
// - Aux sampled once per cycle after demag blank
module ffp_fault_protect #(
  parameter int unsigned OLP_CYC = ffp_pkg::OLP_DEBOUNCE_NS / ffp_pkg::CLK_PERIOD_NS,
  parameter int unsigned AR_CYC = ffp_pkg::AR_PERIOD_NS / ffp_pkg::CLK_PERIOD_NS,
  parameter int unsigned LAR_CYC = ffp_pkg::LAR_PERIOD_NS / ffp_pkg::CLK_PERIOD_NS,
  parameter int unsigned UV_BLANK_CYC = ffp_pkg::UV_BLANK_NS / ffp_pkg::CLK_PERIOD_NS
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Modulator timing
  input wire logic cycleStart,
  input wire logic pwmOff,
  input wire logic demagBlankEnd,
  // Comparators
  input wire logic auxOvCmp,
  input wire logic auxUvCmp,
  input wire logic csShortCmp,
  input wire logic secShortCmp,
  input wire logic fbOverloadCmp,
  input wire logic supplyOn,
  // Power switch and interrupt
  output logic gateDrive,
  output logic irq
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    ffp_pkg::ffp_state_t st;
    logic gate;
    logic [15:0] onTmr;
    logic csSeen;
    logic ssTrip;
    logic [31:0] olpTmr;
    logic [31:0] offTmr;
    logic [31:0] blankTmr;
    logic [2:0] ctrl;
    logic [31:0] count;
    logic [ffp_pkg::NUM_EVT-1:0] status;
    logic [ffp_pkg::NUM_EVT-1:0] mask;
    logic [15:0] oncap;
    logic irq;
    logic [31:0] hrdata;
    logic hready;
    logic dphWr;
    logic [7:0] dphAddr;
  } ffp_top_s_t;

  ffp_top_s_t s;
  ffp_top_s_t next_s;

  logic [ffp_pkg::NUM_CNT-1:0] cntStep;
  logic [ffp_pkg::NUM_CNT-1:0] cntCond;
  logic [ffp_pkg::NUM_CNT-1:0] trips;
  logic [8:0] cntLimit [ffp_pkg::NUM_CNT];
  logic olpTrip;
  logic uvBlank;
  logic addrPhase;

  // ----------------------------------------------------------------
  // Consecutive-cycle counters
  // ----------------------------------------------------------------
  // Aux sample point drives over/under-voltage counters
  assign uvBlank = (s.blankTmr != 32'h0000_0000);
  assign cntStep[ffp_pkg::EVT_OV] = demagBlankEnd;
  assign cntStep[ffp_pkg::EVT_UV] = demagBlankEnd;
  assign cntStep[ffp_pkg::EVT_CSSP] = cycleStart;
  assign cntStep[ffp_pkg::EVT_SECONDARY_SHORT_FAULT] = cycleStart;
  assign cntCond[ffp_pkg::EVT_OV] = auxOvCmp;
  assign cntCond[ffp_pkg::EVT_UV] = auxUvCmp && !uvBlank;
  assign cntCond[ffp_pkg::EVT_CSSP] = s.csSeen;
  assign cntCond[ffp_pkg::EVT_SECONDARY_SHORT_FAULT] = s.ssTrip;
  // Over/under-voltage must persist beyond the count, hence the extra one
  assign cntLimit[ffp_pkg::EVT_OV] = {1'b0, s.count[ffp_pkg::CNT_OV_LSB +: 8]} + 9'h001;
  assign cntLimit[ffp_pkg::EVT_UV] = {1'b0, s.count[ffp_pkg::CNT_UV_LSB +: 8]} + 9'h001;
  assign cntLimit[ffp_pkg::EVT_CSSP] = {1'b0, s.count[ffp_pkg::CNT_CSSP_LSB +: 8]};
  assign cntLimit[ffp_pkg::EVT_SECONDARY_SHORT_FAULT] = {1'b0, s.count[ffp_pkg::CNT_SECONDARY_SHORT_FAULT_LSB +: 8]};

  for (genvar i = 0; i < ffp_pkg::NUM_CNT; i++) begin : g_cnt
    ffp_cycle_counter #(.W(9)) u_cnt (
      .clk_sys(clk_sys),
      .resetn(resetn),
      .clear(s.st != ffp_pkg::ST_RUN),
      .step(cntStep[i]),
      .cond(cntCond[i]),
      .limit(cntLimit[i]),
      .trip(trips[i])
    );
  end

  // Overload debounce expiry
  assign olpTrip = (s.olpTmr > OLP_CYC);
  assign addrPhase = hsel && hready && htrans[1];

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [ffp_pkg::NUM_EVT-1:0] evt;
    logic [ffp_pkg::NUM_EVT-1:0] w1c;
    logic fault;
    logic [31:0] rd;
    evt = {olpTrip, trips};
    w1c = '0;
    fault = (s.st == ffp_pkg::ST_RUN) && (|evt);
    rd = 32'h0000_0000;
    next_s = s;

    // Per-cycle flags restart with each switching cycle
    if (cycleStart) begin
      next_s.csSeen = 1'b0;
      next_s.ssTrip = 1'b0;
    end

    // On-time and cycle-by-cycle protection
    if (s.gate) begin
      next_s.onTmr = (s.onTmr == 16'hffff) ? s.onTmr : s.onTmr + 16'h0001;
      if (s.onTmr == 16'(ffp_pkg::CS_DEBOUNCE_CYC) && csShortCmp) begin
        next_s.csSeen = 1'b1;
      end
      if (pwmOff) begin
        next_s.gate = 1'b0;
      end
      if (s.csSeen && s.onTmr >= s.oncap) begin
        next_s.gate = 1'b0;
      end
      if (s.onTmr >= 16'(ffp_pkg::SECONDARY_SHORT_FAULT_BLANK_CYC) && secShortCmp) begin
        next_s.gate = 1'b0;
        next_s.ssTrip = 1'b1;
      end
    end else if (cycleStart && s.st == ffp_pkg::ST_RUN && s.ctrl[ffp_pkg::CTRL_EN_BIT]) begin
      next_s.gate = 1'b1;
      next_s.onTmr = 16'h0000;
    end

    // Overload timer runs only while the feedback sits at its limit
    if (!fbOverloadCmp || s.st != ffp_pkg::ST_RUN) begin
      next_s.olpTmr = 32'h0000_0000;
    end else if (!olpTrip) begin
      next_s.olpTmr = s.olpTmr + 32'h0000_0001;
    end

    // Startup blanking of under-voltage
    if (uvBlank) begin
      next_s.blankTmr = s.blankTmr - 32'h0000_0001;
    end

    // Protection state machine
    case (s.st)
      ffp_pkg::ST_RUN: begin
        if (fault) begin
          next_s.gate = 1'b0;
          next_s.offTmr = AR_CYC;
          next_s.st = ffp_pkg::ST_AR;
          if (evt[ffp_pkg::EVT_OV] && s.ctrl[ffp_pkg::CTRL_OVLATCH_BIT]) begin
            next_s.st = ffp_pkg::ST_LATCH;
          end else if (evt[ffp_pkg::EVT_UV] && s.ctrl[ffp_pkg::CTRL_UVLONG_BIT]) begin
            next_s.st = ffp_pkg::ST_LAR;
            next_s.offTmr = LAR_CYC;
          end
        end
      end
      ffp_pkg::ST_AR, ffp_pkg::ST_LAR: begin
        next_s.gate = 1'b0;
        if (s.offTmr != 32'h0000_0000) begin
          next_s.offTmr = s.offTmr - 32'h0000_0001;
        end else if (supplyOn) begin
          next_s.st = ffp_pkg::ST_RUN;
          next_s.blankTmr = UV_BLANK_CYC;
        end
      end
      ffp_pkg::ST_LATCH: begin
        next_s.gate = 1'b0;
      end
      default: begin
        next_s.st = ffp_pkg::ST_LATCH;
        next_s.gate = 1'b0;
      end
    endcase

    // Register writes in the data phase
    if (s.dphWr) begin
      case (s.dphAddr)
        ffp_pkg::OFS_CTRL: next_s.ctrl = hwdata[2:0];
        ffp_pkg::OFS_COUNT: next_s.count = hwdata;
        ffp_pkg::OFS_STATUS: w1c = hwdata[ffp_pkg::NUM_EVT-1:0];
        ffp_pkg::OFS_MASK: next_s.mask = hwdata[ffp_pkg::NUM_EVT-1:0];
        ffp_pkg::OFS_ONCAP: next_s.oncap = hwdata[15:0];
        default: w1c = '0;
      endcase
    end

    // Sticky status; a fresh event beats a same-cycle clear
    next_s.status = (s.status & ~w1c) | (fault ? evt : '0);
    // A set mask bit hides its event from irq, the status bit still records it
    next_s.irq = |(next_s.status & ~next_s.mask);

    // Read data from the updated view to avoid stale write-then-read
    case (haddr[7:0])
      ffp_pkg::OFS_CTRL: rd = {29'h0000_0000, next_s.ctrl};
      ffp_pkg::OFS_COUNT: rd = next_s.count;
      ffp_pkg::OFS_STATUS: rd = {27'h000_0000, next_s.status};
      ffp_pkg::OFS_MASK: rd = {27'h000_0000, next_s.mask};
      ffp_pkg::OFS_STATE: rd = {28'h000_0000, uvBlank, next_s.gate, next_s.st};
      ffp_pkg::OFS_ONCAP: rd = {16'h0000, next_s.oncap};
      default: rd = 32'h0000_0000;
    endcase

    // Bus phases; zero wait states so every address phase is taken
    next_s.hready = 1'b1;
    next_s.dphWr = addrPhase && hwrite;
    next_s.dphAddr = haddr[7:0];
    if (addrPhase && !hwrite) begin
      next_s.hrdata = rd;
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      s <= '0;
      s.blankTmr <= UV_BLANK_CYC;
      s.ctrl <= ffp_pkg::RST_CTRL;
      s.count <= ffp_pkg::RST_COUNT;
      s.oncap <= ffp_pkg::RST_ONCAP;
    end else begin
      s <= next_s;
    end
  end

  // Outputs straight from flops, except hresp tied to zero
  assign gateDrive = s.gate;
  assign irq = s.irq;
  assign hrdata = s.hrdata;
  assign hreadyout = s.hready;
  assign hresp = 1'b0;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  a_ov_stops_gate: assert property (
    s.st == ffp_pkg::ST_RUN && trips[ffp_pkg::EVT_OV] |=> !s.gate [*3])
    else $error("switching continued after aux over-voltage");

  a_ov_latch_mode: assert property (
    s.st == ffp_pkg::ST_RUN && trips[ffp_pkg::EVT_OV] && s.ctrl[ffp_pkg::CTRL_OVLATCH_BIT]
    |=> s.st == ffp_pkg::ST_LATCH && s.status[ffp_pkg::EVT_OV])
    else $error("over-voltage did not latch");

  a_uv_long_mode: assert property (
    s.st == ffp_pkg::ST_RUN && trips[ffp_pkg::EVT_UV] && !trips[ffp_pkg::EVT_OV]
    && s.ctrl[ffp_pkg::CTRL_UVLONG_BIT] |=> s.st == ffp_pkg::ST_LAR && s.status[ffp_pkg::EVT_UV])
    else $error("under-voltage did not enter long restart");

  a_uv_blank_hold: assert property (
    uvBlank && $past(uvBlank) |-> !trips[ffp_pkg::EVT_UV])
    else $error("under-voltage fault during startup blanking");

  a_cs_cap_off: assert property (
    s.gate && s.csSeen && s.onTmr >= s.oncap |=> !s.gate)
    else $error("on-time not capped after sense short");

  a_cssp_restart: assert property (
    s.st == ffp_pkg::ST_RUN && trips[ffp_pkg::EVT_CSSP] && !trips[ffp_pkg::EVT_OV]
    && !trips[ffp_pkg::EVT_UV] |=> s.st == ffp_pkg::ST_AR && !s.gate)
    else $error("sense short run did not auto-restart");

  a_secondary_short_fault_off_now: assert property (
    s.gate && s.onTmr >= 16'(ffp_pkg::SECONDARY_SHORT_FAULT_BLANK_CYC) && secShortCmp |=> !s.gate && s.ssTrip)
    else $error("secondary short did not turn switch off");

  a_secondary_short_fault_restart: assert property (
    s.st == ffp_pkg::ST_RUN && trips[ffp_pkg::EVT_SECONDARY_SHORT_FAULT] && !trips[ffp_pkg::EVT_OV]
    && !trips[ffp_pkg::EVT_UV] |=> s.st == ffp_pkg::ST_AR)
    else $error("secondary short run did not auto-restart");

  a_olp_timer_run: assert property (
    s.st == ffp_pkg::ST_RUN && fbOverloadCmp && !olpTrip |=> s.olpTmr == $past(s.olpTmr) + 1)
    else $error("overload timer not counting");

  a_olp_trip_ar: assert property (
    s.st == ffp_pkg::ST_RUN && olpTrip && trips == '0
    |=> s.st == ffp_pkg::ST_AR && s.status[ffp_pkg::EVT_OLP])
    else $error("overload did not shut down");

  a_olp_timer_clr: assert property (
    !fbOverloadCmp |=> s.olpTmr == 32'h0000_0000)
    else $error("overload timer not cleared");

  a_lar_hold_off: assert property (
    s.st == ffp_pkg::ST_LAR && s.offTmr != 32'h0000_0000 |=> !s.gate && s.st == ffp_pkg::ST_LAR)
    else $error("switch active in long restart hold");

  // Halted states never drive the switch, whatever the modulator asks
  a_halt_no_gate: assert property (
    s.st != ffp_pkg::ST_RUN |=> !s.gate)
    else $error("switch driven outside run state");

  a_lar_resume: assert property (
    s.st == ffp_pkg::ST_LAR && s.offTmr == 32'h0000_0000 && supplyOn
    |=> s.st == ffp_pkg::ST_RUN)
    else $error("long restart did not resume with supply up");

  // Polarity guard: irq follows only the unmasked status bits
  a_irq_unmasked: assert property (
    s.irq == |(s.status & ~s.mask))
    else $error("interrupt level disagrees with unmasked status");

  c_ov_latch: cover property (s.st == ffp_pkg::ST_RUN ##1 s.st == ffp_pkg::ST_LATCH);
  c_uv_long: cover property (s.st == ffp_pkg::ST_LAR ##1 s.st == ffp_pkg::ST_RUN);
  c_olp_trip: cover property (olpTrip && s.st == ffp_pkg::ST_RUN);
  c_secondary_short_fault_cut: cover property (s.gate && secShortCmp ##1 s.ssTrip);
  c_cs_cap: cover property (s.gate && s.csSeen ##1 !s.gate);

endmodule : ffp_fault_protect

// >>> bench/ffp_power_model.sv
`timescale 1ns/1ns
// Far side: modulator timing strobes and analog comparators
module ffp_power_model #(
  parameter int PER = 80,
  parameter int ON = 50
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // Scenario control and switch state
  input wire logic [5:0] fault,
  input wire logic gateDrive,
  // Timing strobes
  output logic cycleStart,
  output logic pwmOff,
  output logic demagBlankEnd,
  // Comparator levels
  output logic auxOvCmp,
  output logic auxUvCmp,
  output logic csShortCmp,
  output logic secShortCmp,
  output logic fbOverloadCmp,
  output logic supplyOn
);
  int tmr;

  // Free-running switching period, restarted by reset
  always_ff @(posedge clk_sys) begin
    if (!resetn) tmr <= 0;
    else tmr <= (tmr == PER - 1) ? 0 : tmr + 1;
  end

  // Strobes derived from the period timer
  assign cycleStart = resetn && tmr == 0;
  assign pwmOff = tmr >= ON;
  assign demagBlankEnd = tmr == PER - 10;
  // Levels follow the scenario; secondary short reaches short level only while conducting
  assign auxOvCmp = fault[0];
  assign auxUvCmp = fault[1];
  assign csShortCmp = fault[2];
  assign secShortCmp = fault[3] && gateDrive;
  assign fbOverloadCmp = fault[4] || (fault[5] && tmr < 30); // Short bursts stay below debounce
  assign supplyOn = 1'b1;
endmodule : ffp_power_model

// >>> bench/flyback_fault_protection_test.sv
`timescale 1ns/1ns
module flyback_fault_protection_test;
  localparam int AR = 20;
  localparam int LAR = 300;
  // Per fault case: comparator mask, control, event bit, count field, state, on-time window
  localparam logic [5:0] FLT [7] = '{1, 1, 2, 2, 4, 8, 16};
  localparam logic [31:0] CTL [7] = '{1, 3, 1, 5, 1, 1, 1};
  localparam int EVT [7] = '{0, 0, 1, 1, 2, 3, 4};
  localparam int SH [7] = '{0, 0, 8, 8, 16, 24, 0};
  localparam int ST [7] = '{1, 3, 1, 2, 1, 1, 1};
  localparam int LO [7] = '{48, 48, 48, 48, 38, 19, 0};
  localparam int HI [7] = '{52, 52, 52, 52, 42, 23, 99};
  logic clk_sys = 0;
  logic resetn = 0;
  logic hsel = 0;
  logic [31:0] haddr = 0;
  logic [1:0] htrans = 0;
  logic hwrite = 0;
  logic [31:0] hwdata = 0;
  logic [5:0] fault = 0;
  logic [31:0] hrdata, rd, cnt;
  logic hreadyout, hresp, gateDrive, irq, cycleStart, pwmOff, demagBlankEnd;
  logic auxOvCmp, auxUvCmp, csShortCmp, secShortCmp, fbOverloadCmp, supplyOn;
  int mismatches = 0;
  int n_checks = 0;
  int onCnt = 0;
  int lastOn = 0;
  int nCyc, t, offT, c, cls;

  ffp_fault_protect #(.OLP_CYC(50), .AR_CYC(AR), .LAR_CYC(LAR), .UV_BLANK_CYC(400))
    ffp_fault_protect_inst (.clk_sys(clk_sys), .resetn(resetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .cycleStart(cycleStart),
    .pwmOff(pwmOff), .demagBlankEnd(demagBlankEnd), .auxOvCmp(auxOvCmp), .auxUvCmp(auxUvCmp),
    .csShortCmp(csShortCmp), .secShortCmp(secShortCmp), .fbOverloadCmp(fbOverloadCmp),
    .supplyOn(supplyOn), .gateDrive(gateDrive), .irq(irq));
  ffp_power_model ffp_power_model_inst (.clk_sys(clk_sys), .resetn(resetn), .fault(fault),
    .gateDrive(gateDrive), .cycleStart(cycleStart), .pwmOff(pwmOff),
    .demagBlankEnd(demagBlankEnd), .auxOvCmp(auxOvCmp), .auxUvCmp(auxUvCmp),
    .csShortCmp(csShortCmp), .secShortCmp(secShortCmp), .fbOverloadCmp(fbOverloadCmp),
    .supplyOn(supplyOn));

  always #5 clk_sys = ~clk_sys;

  // Length of the latest switch pulse, kept when the gate drops
  always @(posedge clk_sys) begin
    if (gateDrive === 1'b1) onCnt <= onCnt + 1;
    else begin
      if (onCnt > 0) lastOn <= onCnt;
      onCnt <= 0;
    end
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task give_verdict;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : give_verdict

  // One single AHB-Lite transfer, entered just after a rising edge
  task bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'b10;
    hsel <= 1'b1;
    do begin @(posedge clk_sys); n++; end while (hreadyout !== 1'b1 && n < 40);
    htrans <= 2'b00;
    hwdata <= wd;
    do begin @(posedge clk_sys); n++; end while (hreadyout !== 1'b1 && n < 40);
    rd = hrdata;
    if (n >= 40) begin mismatches++; give_verdict(); end
  endtask : bus

  task rst;
    fault <= 0;
    resetn <= 0;
    repeat (4) @(posedge clk_sys);
    resetn <= 1;
    @(posedge clk_sys);
  endtask : rst

  // Returns at the edge that takes the k-th turn-on request
  task cycles(input int k);
    int n;
    for (int i = 0; i < k; i++) begin
      n = 0;
      do begin @(posedge clk_sys); n++; end while (cycleStart !== 1'b1 && n < 200);
    end
  endtask : cycles

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    c = $urandom(32'h936d55fd);
    rst();
    bus(0, ffp_pkg::OFS_CTRL, 0); check(rd, {29'h0, ffp_pkg::RST_CTRL});
    bus(0, ffp_pkg::OFS_COUNT, 0); check(rd, ffp_pkg::RST_COUNT);
    bus(0, ffp_pkg::OFS_ONCAP, 0); check(rd, {16'h0, ffp_pkg::RST_ONCAP});
    bus(0, 8'h40, 0); check(rd, 0);
    bus(0, ffp_pkg::OFS_STATE, 0); check(rd[3], 1'b1);
    check(hresp, 1'b0);
    // Low aux and short overload bursts while the startup blank runs
    bus(1, ffp_pkg::OFS_MASK, 0);
    bus(1, ffp_pkg::OFS_COUNT, 32'h04040004);
    fault <= 6'h22;
    cycles(3); check(irq, 1'b0);
    fault <= 6'h20;
    cycles(6); check(irq, 1'b0);
    // Over-voltage runs broken by clean cycles never trip
    bus(1, ffp_pkg::OFS_COUNT, 32'h04040401);
    cycles(1);
    repeat (3) begin fault <= 6'h01; cycles(1); fault <= 6'h00; cycles(1); end
    bus(0, ffp_pkg::OFS_STATUS, 0); check(rd, 0);
    // Enable cleared: turn-on requests must be ignored
    bus(1, ffp_pkg::OFS_CTRL, 0);
    cycles(1);
    repeat (10) @(posedge clk_sys);
    check(gateDrive, 1'b0);
    bus(0, ffp_pkg::OFS_STATE, 0); check(rd[2], 1'b0);
    // Each fault kind: trip count (except overload), stop, status, state, mask, clear, off time
    for (int k = 0; k < 7; k++) begin
      rst();
      c = $urandom_range(1, 3);
      cnt = (32'h04040404 & ~(32'hff << SH[k])) | (c << SH[k]);
      bus(1, ffp_pkg::OFS_MASK, 0);
      bus(1, ffp_pkg::OFS_CTRL, CTL[k]);
      bus(1, ffp_pkg::OFS_ONCAP, 40);
      bus(1, ffp_pkg::OFS_COUNT, cnt); bus(0, ffp_pkg::OFS_COUNT, 0); check(rd, cnt);
      cycles(6);
      fault <= FLT[k];
      nCyc = 1;
      t = 0;
      do begin
        @(posedge clk_sys);
        t++;
        if (cycleStart === 1'b1) nCyc++;
      end while (irq !== 1'b1 && t < 3000);
      if (t >= 3000) begin mismatches++; give_verdict(); end
      fault <= 0;
      if (k < 6) check(nCyc, c + 1);
      check(lastOn >= LO[k] && lastOn <= HI[k], 1'b1);
      check(gateDrive, 1'b0);
      bus(0, ffp_pkg::OFS_STATE, 0); check(rd[1:0], ST[k]);
      offT = 3;
      while (gateDrive !== 1'b1 && offT < 1000) begin @(posedge clk_sys); offT++; end
      cls = (offT >= 1000) ? 3 : (offT >= LAR) ? 2 : (offT >= AR) ? 1 : 0;
      check(cls, ST[k]);
      bus(0, ffp_pkg::OFS_STATUS, 0); check(rd, 32'h1 << EVT[k]);
      bus(1, ffp_pkg::OFS_MASK, 32'h1f);
      repeat (2) @(posedge clk_sys);
      check(irq, 1'b0);
      bus(1, ffp_pkg::OFS_MASK, 0);
      repeat (2) @(posedge clk_sys);
      check(irq, 1'b1);
      bus(1, ffp_pkg::OFS_STATUS, 32'h1 << EVT[k]);
      bus(0, ffp_pkg::OFS_STATUS, 0); check(rd, 0);
      repeat (2) @(posedge clk_sys);
      check(irq, 1'b0);
    end
    give_verdict();
  end
endmodule : flyback_fault_protection_test
